// [include/ssts_defines.svh]
// register map, field positions, reset values and timing figures of the scan sequencer
`ifndef SSTS_DEFINES_SVH
`define SSTS_DEFINES_SVH
// ***************
// register offsets
// ***************
`define SSTS_A_CTRL   8'h00
`define SSTS_A_SETUP  8'h04
`define SSTS_A_RATE   8'h08
`define SSTS_A_SLOT   8'h0c
`define SSTS_A_LEN    8'h10
`define SSTS_A_LADDR  8'h14
`define SSTS_A_LDATA  8'h18
`define SSTS_A_TCEN   8'h1c
`define SSTS_A_STAT   8'h20
// ***************
// field positions
// ***************
`define SSTS_B_BEGIN  0
`define SSTS_B_STOP   1
`define SSTS_B_EXT    6
`define SSTS_B_PULSE  7
`define SSTS_B_RUN    0
`define SSTS_B_OVL    1
`define SSTS_B_OVF    2
// ***************
// reset values
// ***************
`define SSTS_R_RATE   24'h0009c4
`define SSTS_R_SLOT   16'h0014
`define SSTS_R_LEN    8'h01
// ***************
// channel codes and figures
// ***************
`define SSTS_CH_FLEX  8'hc1
`define SSTS_CH_CTRL  8'hc2
`define SSTS_CH_TMR0  8'hc8
`define SSTS_CH_TMR5  8'hcd
`define SSTS_CH_CNT0  8'hd2
`define SSTS_CH_HIGH  8'he0
`define SSTS_LIST_MAX 128
`define SSTS_PKT_N    16
`define SSTS_PULSE_NS 6000
`define SSTS_CLK_NS   4
`endif

// [include/ssts_pkg.sv]
// types shared by the stream scan trigger sequencer
package ssts_pkg;
  typedef enum logic [0:0] {SSTS_IDLE, SSTS_SAMPLE} ssts_state_t;
  // digital pin bundle sampled by the port entries
  typedef struct packed {
    logic [7:0] extended_lines;
    logic [7:0] control_lines;
    logic [7:0] multiplexer_lines;
  } ssts_pins_t;
  // error and run flags shown in status
  typedef struct packed {
    logic overflow;
    logic overlap;
    logic running;
  } ssts_stat_t;
endpackage

// [src/ssts_sequencer.sv]
// stream scan trigger sequencer: scan timing, trigger, pulse out, special entries, packets
//
// Contract
// (RL1) scans start from internal clock, or falling edges when trigger option set
// (RL2) pulse option keeps internal timing and emits one pulse per scan
// (RL3) pulse idles high, goes low at scan start, high after about 6 us
// (RL4) list holds up to 128 entries, repeats allowed, sampled in order
// (RL5) packets carry exactly sixteen samples, none sent before sixteen gathered
// (RL6) stream timing counter is reserved while a stream runs
// (RL7) assigned flex line follows enabled timers/counters, else flex line zero
// (RL8) setup with pulse option makes line output at once, pulses on start
// (RL9) setup with trigger option makes line input at once, edges after start
// (RL10) one trigger edge gives exactly one scan
// (RL11) host should not change timer setup while trigger or pulse in use
// (RL12) entry 193 gives flex lines low byte, extended lines high byte
// (RL13) entry 194 gives control lines low byte, multiplexer lines high byte
// (RL14) entries 200-205 give timer low halves, 210 event counter low half
// (RL15) sampling a low half latches its high half; entry 224 reads it
// (RL16) host places 224 right after a unit's entry; later units overwrite
// (RL17) special entries reconfigure nothing; lines read as they stand
// (RL18) every entry takes one slot of equal timing
// (RL19) halves of 32-bit period timers may be incoherent
// (RL20) system timer upper word is not a stream source
// (RL21) internal scans begin one rate interval apart, samples back to back
// (RL22) samples are held in a large buffer until the host takes them; the code holds one finished packet behind a 16-sample assembly buffer
// (RL23) over capacity reports overlap or overflow, never corrupt samples
// (RL24) start request during a scan flags overlap, no second scan
// (RL25) after stop no pulses and trigger edges ignored until restart
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ssts_defines.svh"
module ssts_sequencer
  import ssts_pkg::*;
#(
  parameter int LIST_N = `SSTS_LIST_MAX
) (
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // flex line pins
  input  wire logic [7:0]          flex_in,
  output logic [7:0]               flex_out,
  output logic [7:0]               flex_oe_n,
  // other digital pins
  input  wire ssts_pins_t          pins_in,
  // timer and counter values, index 6 is event_counter_zero
  input  wire logic [6:0][31:0]    tc_value,
  // analog sample source
  output logic [7:0]               adc_chan,
  input  wire logic [15:0]         adc_data,
  // packet out
  output logic                     pkt_valid,
  input  wire logic                pkt_ready,
  output logic [`SSTS_PKT_N*16-1:0] pkt_data,
  // stream timing counter reservation
  output logic                     timing_counter_busy
);
  localparam int PULSE_CYC = (`SSTS_PULSE_NS + `SSTS_CLK_NS - 1) / `SSTS_CLK_NS;
  localparam int IW = $clog2(LIST_N);

  // ********************
  // state
  // ********************
  logic              ext_opt_q, pulse_opt_q;
  logic [23:0]       rate_q, rate_cnt_q;
  logic [15:0]       slot_q, slot_cnt_q;
  logic [7:0]        len_q;
  logic [IW-1:0]     laddr_q, idx_q;
  logic [7:0]        list_q [LIST_N];
  logic [6:0]        tcen_q;
  ssts_stat_t        stat_q;
  ssts_state_t       state_q;
  logic [10:0]       pulse_cnt_q;
  logic [15:0]       capt_q;
  logic [15:0][15:0] buf_q;
  logic [3:0]        fill_q;
  logic [`SSTS_PKT_N*16-1:0] pkt_q;
  logic              pkt_valid_q;
  logic [7:0]        flex_s1_q, flex_s2_q;
  ssts_pins_t        pins_s1_q, pins_s2_q;
  logic              trig_prev_q;
  logic [31:0]       prdata_q;

  // ********************
  // apb decode
  // ********************
  wire wr      = psel & penable & pwrite;
  wire rd_set  = psel & ~penable & ~pwrite;
  wire hit_ctl = paddr == `SSTS_A_CTRL;
  wire hit_set = paddr == `SSTS_A_SETUP;
  wire hit_rat = paddr == `SSTS_A_RATE;
  wire hit_slt = paddr == `SSTS_A_SLOT;
  wire hit_len = paddr == `SSTS_A_LEN;
  wire hit_lad = paddr == `SSTS_A_LADDR;
  wire hit_lda = paddr == `SSTS_A_LDATA;
  wire hit_tce = paddr == `SSTS_A_TCEN;
  wire hit_sta = paddr == `SSTS_A_STAT;
  wire mapped  = hit_ctl | hit_set | hit_rat | hit_slt | hit_len | hit_lad | hit_lda | hit_tce | hit_sta;
  wire begin_w = wr & hit_ctl & pwdata[`SSTS_B_BEGIN];
  wire stop_w  = wr & hit_ctl & pwdata[`SSTS_B_STOP];
  // zero wait states; read data is loaded in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  // ********************
  // pin synchronisers
  // ********************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flex_s1_q <= 8'hff;
      flex_s2_q <= 8'hff;
      pins_s1_q <= '0;
      pins_s2_q <= '0;
    end else if (ce) begin
      flex_s1_q <= flex_in;
      flex_s2_q <= flex_s1_q;
      pins_s1_q <= pins_in;
      pins_s2_q <= pins_s1_q;
    end
  end

  // ********************
  // line assignment
  // ********************
  // assigned line sits after all enabled units; none enabled gives line zero
  logic [2:0] line_sel;
  always_comb begin
    line_sel = 3'h0;
    for (int i = 0; i < 7; i++) line_sel = line_sel + {2'h0, tcen_q[i]}; // RL7
  end
  wire line_in   = flex_s2_q[line_sel];
  wire pulse_low = pulse_cnt_q != 11'h000;
  // direction follows the setup option at once, not the stream state
  assign flex_oe_n = pulse_opt_q ? ~(8'h01 << line_sel) : 8'hff; // RL8 RL9
  assign flex_out  = pulse_low ? ~(8'h01 << line_sel) : 8'hff;   // RL3
  assign timing_counter_busy = stat_q.running;                   // RL6

  // ********************
  // scan start logic
  // ********************
  wire internal  = ~ext_opt_q | pulse_opt_q;
  wire int_tick  = stat_q.running & internal & (rate_cnt_q == 24'h0); // RL1 RL21
  // edges count only while running, so setup alone never fires a scan
  wire trig_fall = stat_q.running & ~internal & trig_prev_q & ~line_in; // RL1 RL9 RL25
  wire start_req = int_tick | trig_fall;
  wire busy      = state_q == SSTS_SAMPLE;
  wire start_ok  = start_req & ~busy;        // RL10
  wire overlap   = start_req & busy;         // RL24
  wire slot_end  = busy & (slot_cnt_q == 16'h0);
  wire last_ent  = {1'b0, idx_q} == len_q - 8'h01;

  // ********************
  // entry decode
  // ********************
  wire [7:0] code   = list_q[idx_q];
  wire is_tmr       = code >= `SSTS_CH_TMR0 && code <= `SSTS_CH_TMR5;
  wire is_tc        = is_tmr | (code == `SSTS_CH_CNT0);
  wire [2:0] tc_sel = is_tmr ? 3'(code - `SSTS_CH_TMR0) : 3'h6;
  wire [31:0] tc_w  = tc_value[tc_sel];
  logic [15:0] sample;
  // special entries only read; no direction or timer state is touched
  always_comb begin
    case (code)
      `SSTS_CH_FLEX: sample = {pins_s2_q.extended_lines, flex_s2_q};           // RL12 RL17
      `SSTS_CH_CTRL: sample = {pins_s2_q.multiplexer_lines, pins_s2_q.control_lines}; // RL13
      `SSTS_CH_HIGH: sample = capt_q;                                           // RL15
      default:       sample = is_tc ? tc_w[15:0] : (code < 8'hc0 ? adc_data : 16'h0); // RL14 RL20
    endcase
  end
  assign adc_chan = code;

  // ********************
  // packet assembly
  // ********************
  wire commit   = ce & slot_end & stat_q.running;
  wire pkt_full = commit & (fill_q == 4'hf);
  // a full packet with the previous one unclaimed is dropped whole, not torn
  wire overflow = pkt_full & pkt_valid_q & ~pkt_ready; // RL23
  assign pkt_valid = pkt_valid_q;
  assign pkt_data  = pkt_q;

  // ********************
  // register file
  // ********************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_opt_q   <= 1'b0;
      pulse_opt_q <= 1'b0;
      rate_q      <= `SSTS_R_RATE;
      slot_q      <= `SSTS_R_SLOT;
      len_q       <= `SSTS_R_LEN;
      laddr_q     <= '0;
      tcen_q      <= 7'h00;
      prdata_q    <= 32'h0;
    end else if (ce) begin
      if (wr & hit_set) begin
        ext_opt_q   <= pwdata[`SSTS_B_EXT];
        pulse_opt_q <= pwdata[`SSTS_B_PULSE];
      end
      if (wr & hit_rat) rate_q <= pwdata[23:0];
      if (wr & hit_slt) slot_q <= pwdata[15:0];
      if (wr & hit_len) len_q <= (pwdata[7:0] > 8'(LIST_N)) ? 8'(LIST_N) : pwdata[7:0]; // RL4
      if (wr & hit_lad) laddr_q <= pwdata[IW-1:0];
      else if (wr & hit_lda) laddr_q <= laddr_q + 1'b1;
      if (wr & hit_tce) tcen_q <= pwdata[6:0];
      if (rd_set) begin
        case (paddr)
          `SSTS_A_SETUP: prdata_q <= {24'h0, pulse_opt_q, ext_opt_q, 6'h0};
          `SSTS_A_RATE:  prdata_q <= {8'h0, rate_q};
          `SSTS_A_SLOT:  prdata_q <= {16'h0, slot_q};
          `SSTS_A_LEN:   prdata_q <= {24'h0, len_q};
          `SSTS_A_LADDR: prdata_q <= 32'(laddr_q);
          `SSTS_A_LDATA: prdata_q <= {24'h0, list_q[laddr_q]};
          `SSTS_A_TCEN:  prdata_q <= {25'h0, tcen_q};
          `SSTS_A_STAT:  prdata_q <= {21'h0, line_sel, 5'h0, stat_q};
          default:       prdata_q <= 32'h0;
        endcase
      end
    end
  end

  // list storage, one flop row per entry
  for (genvar g = 0; g < LIST_N; g++) begin : g_list
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) list_q[g] <= 8'h00;
      else if (ce && wr && hit_lda && laddr_q == IW'(g)) list_q[g] <= pwdata[7:0]; // RL4
    end
  end

  // ********************
  // run and error flags
  // ********************
  // error sets win over a same-cycle write-one clear
  wire clr_ovl = wr & hit_sta & pwdata[`SSTS_B_OVL];
  wire clr_ovf = wr & hit_sta & pwdata[`SSTS_B_OVF];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stat_q <= '0;
    else if (ce) begin
      stat_q.running  <= begin_w ? 1'b1 : (stop_w | overflow) ? 1'b0 : stat_q.running;
      stat_q.overlap  <= overlap | (stat_q.overlap & ~clr_ovl);   // RL24
      stat_q.overflow <= overflow | (stat_q.overflow & ~clr_ovf); // RL23
    end
  end

  // ********************
  // scan sequencer
  // ********************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= SSTS_IDLE;
      idx_q      <= '0;
      slot_cnt_q <= 16'h0;
      rate_cnt_q <= 24'h0;
    end else if (ce) begin
      if (begin_w | ~stat_q.running) rate_cnt_q <= 24'h0;
      else if (int_tick) rate_cnt_q <= rate_q - 24'h1;               // RL21
      else if (rate_cnt_q != 24'h0) rate_cnt_q <= rate_cnt_q - 24'h1;
      case (state_q)
        SSTS_IDLE: begin
          idx_q <= '0;
          if (start_ok) begin
            state_q    <= SSTS_SAMPLE;
            slot_cnt_q <= slot_q;
          end
        end
        SSTS_SAMPLE: begin
          if (~stat_q.running) state_q <= SSTS_IDLE;                 // RL25
          else if (slot_end) begin
            slot_cnt_q <= slot_q;                                    // RL18
            if (last_ent) state_q <= SSTS_IDLE;
            else idx_q <= idx_q + 1'b1;                              // RL4
          end else slot_cnt_q <= slot_cnt_q - 16'h1;
        end
        default: state_q <= SSTS_IDLE;
      endcase
    end
  end

  // ********************
  // high half latch, trigger history, pulse
  // ********************
  // pulse ends in the same edge as a stop, an overflow or a cleared option lands,
  // so the line is never seen low one cycle after the stream has already ended
  wire pulse_kill = stop_w | overflow | (wr & hit_set & ~pwdata[`SSTS_B_PULSE]);
  // no hold on low-half rollover, so halves of a running period timer may disagree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      capt_q      <= 16'h0;
      trig_prev_q <= 1'b1;
      pulse_cnt_q <= 11'h0;
    end else if (ce) begin
      if (commit & is_tc) capt_q <= tc_w[31:16];                      // RL15 RL19
      trig_prev_q <= line_in;
      if (~stat_q.running | ~pulse_opt_q | pulse_kill) pulse_cnt_q <= 11'h0; // RL25
      else if (start_ok) pulse_cnt_q <= 11'(PULSE_CYC);               // RL2 RL3
      else if (pulse_low) pulse_cnt_q <= pulse_cnt_q - 11'h1;
    end
  end

  // packet buffer: first sample of a packet lands in the low word
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_q       <= '0;
      fill_q      <= 4'h0;
      pkt_q       <= '0;
      pkt_valid_q <= 1'b0;
    end else if (ce) begin
      if (begin_w) fill_q <= 4'h0;
      else if (commit) begin
        buf_q  <= {sample, buf_q[15:1]};
        fill_q <= fill_q + 4'h1;                                       // RL5
      end
      if (pkt_full & ~overflow) begin
        pkt_q       <= {sample, buf_q[15:1]};                          // RL5 RL22
        pkt_valid_q <= 1'b1;
      end else if (pkt_ready) pkt_valid_q <= 1'b0;
    end
  end

  // ********************
  // checks
  // ********************
  logic [10:0] low_len_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) low_len_q <= 11'h0;
    else if (ce) low_len_q <= pulse_low ? low_len_q + 11'h1 : 11'h0;
  end
  chk_pulse_width_max: assert property (@(posedge clk) disable iff (!reset_n) // RL3
    low_len_q <= 11'(PULSE_CYC)) else $error("scan pulse low too long");
  chk_pulse_only_run: assert property (@(posedge clk) disable iff (!reset_n) // RL25
    pulse_low |-> stat_q.running && pulse_opt_q) else $error("pulse outside stream");
  chk_pulse_on_start: assert property (@(posedge clk) disable iff (!reset_n) // RL2
    ce && start_ok && stat_q.running && pulse_opt_q |=> pulse_low) else $error("scan gave no pulse");
  chk_overlap_flag: assert property (@(posedge clk) disable iff (!reset_n) // RL24
    ce && start_req && busy |=> stat_q.overlap && busy) else $error("overlap not flagged");
  chk_one_scan_edge: assert property (@(posedge clk) disable iff (!reset_n) // RL10
    ce && trig_fall && !busy |=> busy && idx_q == '0) else $error("trigger edge lost");
  chk_no_idle_edge: assert property (@(posedge clk) disable iff (!reset_n) // RL25
    ce && !stat_q.running && state_q == SSTS_IDLE |=> state_q == SSTS_IDLE) else $error("scan while stopped");
  chk_packet_sixteen: assert property (@(posedge clk) disable iff (!reset_n) // RL5
    $rose(pkt_valid_q) |-> $past(fill_q) == 4'hf && fill_q == 4'h0) else $error("short packet");
  chk_high_latch: assert property (@(posedge clk) disable iff (!reset_n) // RL15
    commit && is_tc |=> capt_q == $past(tc_w[31:16])) else $error("high half not latched");
  chk_line_dir: assert property (@(posedge clk) disable iff (!reset_n) // RL8
    pulse_opt_q |-> !flex_oe_n[line_sel] && $countones(~flex_oe_n) == 1) else $error("line direction wrong");

  // ********************
  // sequencing, packet integrity, reservation and pulse checks
  // ********************
  // a dropped packet must leave the held one untouched
  chk_no_torn_packet: assert property (@(posedge clk) disable iff (!reset_n) // RL23
    ce && overflow |=> pkt_q == $past(pkt_q) && pkt_valid_q) else $error("held packet changed");
  chk_overflow_halts: assert property (@(posedge clk) disable iff (!reset_n) // RL23
    ce && overflow && !begin_w |=> !stat_q.running && stat_q.overflow) else $error("overflow kept running");
  // entries advance one by one, each slot counting down without skips
  chk_list_order: assert property (@(posedge clk) disable iff (!reset_n) // RL4
    ce && slot_end && stat_q.running && !last_ent |=> idx_q == $past(idx_q) + 1'b1)
    else $error("list order broken");
  chk_slot_length: assert property (@(posedge clk) disable iff (!reset_n) // RL18
    ce && busy && stat_q.running && !slot_end |=> slot_cnt_q == $past(slot_cnt_q) - 16'h1)
    else $error("slot cut short");
  chk_counter_reserved: assert property (@(posedge clk) disable iff (!reset_n) // RL6
    ce && begin_w |=> timing_counter_busy) else $error("timing counter not reserved");
  chk_pulse_cleared: assert property (@(posedge clk) disable iff (!reset_n) // RL25
    ce && pulse_kill |=> !pulse_low) else $error("pulse outlived stop");
endmodule // ssts_sequencer

// [tb/ssts_host_model.sv]
// host side model: analog source and packet sink for the scan sequencer
`timescale 1ns/1ps
module ssts_host_model (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // analog source
  input  wire logic [7:0]   adc_chan,
  output logic [15:0]       adc_data,
  // packet sink
  input  wire logic         pkt_valid,
  input  wire logic [255:0] pkt_data,
  output logic              pkt_ready,
  input  wire logic         stall
);
  logic [255:0] got[$];

  // result is a fixed function of the code, so the bench can predict every sample
  assign adc_data = {~adc_chan, adc_chan};

  // ready follows the bench's stall wish; stalling is how overflow gets provoked
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) pkt_ready <= 1'b0;
    else pkt_ready <= !stall;
  end

  // the host keeps every packet it takes until the bench drains it
  always @(posedge clk) begin
    if (reset_n && pkt_valid && pkt_ready) got.push_back(pkt_data);
  end
endmodule // ssts_host_model

// [tb/tb_top.sv]
// self-checking bench for the stream scan trigger sequencer
`timescale 1ns/1ps
`include "ssts_defines.svh"
module tb_top import ssts_pkg::*; ;
  logic             clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic [7:0]       paddr = 8'h00, flex_in, flex_out, flex_oe_n, adc_chan;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, pkt_valid, pkt_ready, busy, err;
  ssts_pins_t       pins_in;
  logic [6:0][31:0] tc_value;
  logic [15:0]      adc_data;
  logic [255:0]     pkt_data;
  int               fail_count = 0, n_tests = 0, cyc = 0, seed = 74849, t0;
  int               lst[$];

  ssts_sequencer u_ssts_sequencer (.clk(clk), .reset_n(reset_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flex_in(flex_in), .flex_out(flex_out), .flex_oe_n(flex_oe_n), .pins_in(pins_in), .tc_value(tc_value),
    .adc_chan(adc_chan), .adc_data(adc_data), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_data(pkt_data), .timing_counter_busy(busy));
  ssts_host_model u_ssts_host_model (.clk(clk), .reset_n(reset_n), .adc_chan(adc_chan), .adc_data(adc_data),
    .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_ready(pkt_ready), .stall(stall));

  always #2 clk = ~clk;

  // a hang counts as a mismatch and still ends in the report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic load_list();
    wr(`SSTS_A_LEN, lst.size());
    wr(`SSTS_A_LADDR, 32'h0);
    foreach (lst[k]) wr(`SSTS_A_LDATA, lst[k]);
  endtask

  // falling edges on flex line zero, each held low long enough for one short scan
  task automatic edges(int n);
    repeat (n) begin
      @(posedge clk) flex_in[0] <= 1'b0;
      repeat (30) @(posedge clk);
      flex_in[0] <= 1'b1;
      repeat (30) @(posedge clk);
    end
  endtask

  // bench model of one sample; hi plays the high half latch
  function automatic logic [15:0] smp(int c, inout logic [15:0] hi, input logic [7:0] f);
    logic [15:0] v;
    v = 16'h0;
    if (c < 192) v = {~c[7:0], c[7:0]};
    else if (c == 193) v = {pins_in.extended_lines, f};
    else if (c == 194) v = {pins_in.multiplexer_lines, pins_in.control_lines};
    else if ((c >= 200 && c <= 205) || c == 210) begin
      v = tc_value[(c == 210) ? 6 : c - 200][15:0];
      hi = tc_value[(c == 210) ? 6 : c - 200][31:16];
    end else if (c == 224) v = hi;
    return v;
  endfunction

  task automatic cmp_pkts(logic [7:0] f);
    logic [255:0] p;
    logic [15:0]  hi;
    hi = 16'h0;
    chk("packets", u_ssts_host_model.got.size() > 0, 32'h1);
    while (u_ssts_host_model.got.size() > 0) begin
      p = u_ssts_host_model.got.pop_front();
      for (int i = 0; i < 16; i++) chk("sample", p[i*16 +: 16], smp(lst[i % lst.size()], hi, f));
    end
  endtask

  initial begin
    for (int k = 0; k < 7; k++) tc_value[k] = $random(seed);
    pins_in = $random(seed);
    flex_in = $random(seed) | 1;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // reset values and an unmapped access
    rdc("rate", `SSTS_A_RATE, 32'h9c4);
    rdc("slot", `SSTS_A_SLOT, 32'h14);
    rdc("len", `SSTS_A_LEN, 32'h1);
    rdc("stat", `SSTS_A_STAT, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    chk("slverr", err, 32'h1);
    // pulse output, three units enabled, mixed special list
    lst = {193, 194, 200, 224, 205, 224, 210, 224, 201, 203, 224, 0, 0, 0, 250, 193};
    for (int k = 11; k < 14; k++) lst[k] = $random(seed) & 127;
    load_list();
    wr(`SSTS_A_TCEN, 32'h7);
    wr(`SSTS_A_SLOT, 32'h0);
    wr(`SSTS_A_RATE, 32'h7d0);
    wr(`SSTS_A_SETUP, 32'h80);
    repeat (2) @(posedge clk);
    chk("oe pulse", flex_oe_n, 32'hf7);
    chk("idle", flex_out, 32'hff);
    rdc("line", `SSTS_A_STAT, 32'h300);
    wr(`SSTS_A_CTRL, 32'h1);
    while (flex_out[3] !== 1'b0) @(posedge clk);
    t0 = cyc;
    chk("busy", busy, 32'h1);
    while (flex_out[3] !== 1'b1) @(posedge clk);
    chk("pulse width", cyc - t0, 32'h5dc);
    while (flex_out[3] !== 1'b0) @(posedge clk);
    chk("interval", cyc - t0, 32'h7d0);
    repeat (100) @(posedge clk);
    wr(`SSTS_A_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    t0 = 0;
    repeat (2500) begin
      @(posedge clk);
      if (flex_out[3] !== 1'b1) t0++;
    end
    chk("pulse after stop", t0, 32'h0);
    chk("busy after stop", busy, 32'h0);
    cmp_pkts(flex_in);
    // external trigger on flex line zero; timer setup changed only while stopped
    wr(`SSTS_A_TCEN, 32'h0);
    wr(`SSTS_A_SETUP, 32'h40);
    lst = {193};
    load_list();
    repeat (2) @(posedge clk);
    chk("oe trigger", flex_oe_n, 32'hff);
    edges(3);
    stall <= 1'b1;
    wr(`SSTS_A_CTRL, 32'h1);
    edges(15);
    chk("early packet", pkt_valid, 32'h0);
    edges(1);
    chk("packet", pkt_valid, 32'h1);
    edges(16);
    rdc("overflow", `SSTS_A_STAT, 32'h4);
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_pkts(flex_in & 8'hfe);
    // internal scans longer than the rate interval
    wr(`SSTS_A_SETUP, 32'h0);
    lst = {0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
    load_list();
    wr(`SSTS_A_SLOT, 32'h14);
    wr(`SSTS_A_RATE, 32'h64);
    wr(`SSTS_A_STAT, 32'h6);
    rdc("cleared", `SSTS_A_STAT, 32'h0);
    wr(`SSTS_A_CTRL, 32'h1);
    repeat (1000) @(posedge clk);
    rdc("overlap", `SSTS_A_STAT, 32'h3);
    wr(`SSTS_A_CTRL, 32'h2);
    repeat (20) @(posedge clk);
    cmp_pkts(flex_in);
    summarize();
  end
endmodule // tb_top
